// [hw/bccc_ctrl.v]
// battery charge cycle controller with apb settings and status
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "bccc_map.vh"

module bccc_ctrl #(
	parameter SEC_CYC = `BCCC_SEC_CYC,
	parameter BLINK_CYC = `BCCC_BLINK_CYC,
	parameter INT_CYC = `BCCC_INT_CYC,
	parameter SHORT_HRS = 2,
	parameter TMR_W = 16
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,
	// analog comparators and pins
	input wire charge_enable_n,
	input wire converter_up,
	input wire bat_below_short,
	input wire bat_below_pre,
	input wire bat_below_low,
	input wire bat_above_recharge,
	input wire current_below_term,
	input wire input_current_limit_flag,
	input wire input_voltage_limit_flag,
	input wire thermal_reg_flag,
	input wire ts_in_charge_window,
	input wire ts_cool_zone,
	input wire ts_warm_zone,
	input wire ts_in_boost_window,
	input wire boost_request,
	// regulator controls
	output reg [2:0] current_select_r,
	output reg voltage_select_r,
	output reg [7:0] regulation_voltage_r,
	output reg [7:0] current_code_r,
	output reg battery_switch_r,
	output reg boost_run_r,
	// indicator open drain and host interrupt
	output wire stat_in,
	output reg stat_out_r,
	output reg stat_oe_n_r,
	output reg host_int_r
);

	// cycle states: idle waits for every start qualifier; chg runs the
	// short, precharge or fast phase picked from the battery comparators;
	// top runs the top-off segment that follows termination; done waits
	// for a recharge request or a disable; flt keeps a safety timer
	// expiry latched until charging is disabled, which is its only exit
	localparam ST_IDLE = 3'd0;
	localparam ST_CHG = 3'd1;
	localparam ST_TOP = 3'd2;
	localparam ST_DONE = 3'd3;
	localparam ST_FLT = 3'd4;
	localparam [TMR_W-1:0] ONE_SEC = {{(TMR_W-1){1'b0}}, 1'b1};
	// the short limit in hours as a 32 bit word, cut to the counter width where it is used
	localparam [31:0] SHORT_HRS_W = SHORT_HRS;

	// host settings written over apb
	reg [31:0] ctrl_r;
	reg [31:0] level_r;

	// cycle state and the codes reported in the status word
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [1:0] phase_r;
	reg [1:0] fault_r;
	reg [2:0] src_r;
	reg thermistor_fault_r;

	// top-off length frozen when termination is seen
	reg [1:0] top_sel_r;

	// one second prescaler and the half rate toggle shared by both timers
	reg [31:0] presc_r;
	reg half_r;

	// elapsed seconds of the safety and top-off segments
	reg [TMR_W-1:0] safe_sec_r;
	reg [TMR_W-1:0] top_sec_r;

	// indicator blink and interrupt pulse length
	reg [31:0] blink_cnt_r;
	reg blink_r;
	reg [31:0] int_cnt_r;

	// previous enable and termination levels for the edge detectors
	reg en_q_r;
	reg term_q_r;

	// apb: zero wait states, unmapped offsets read zero and flag error
	// writes to the read-only status word are dropped without an error
	wire apb_acc = psel && penable;
	wire apb_wr = apb_acc && pwrite;
	wire hit = (paddr == `BCCC_OFS_CTRL) || (paddr == `BCCC_OFS_LEVEL) ||
		(paddr == `BCCC_OFS_STATUS);
	assign pready = 1'b1;
	assign pslverr = apb_acc && !hit;
	assign stat_in = 1'b0;

	wire chg_en = ctrl_r[`BCCC_CTL_CHG_EN] && !charge_enable_n;
	wire reg_rst = ctrl_r[`BCCC_CTL_REG_RST];
	wire in_reg = input_current_limit_flag || input_voltage_limit_flag ||
		thermal_reg_flag;
	wire fast_charge_current_nz = level_r[`BCCC_LVL_FAST_CHARGE_CURRENT_LO +: 8] != 8'h00;
	// start qualifiers, thermistor window gates the start as well
	wire can_start = converter_up && chg_en && fast_charge_current_nz && !thermistor_fault_r &&
		fault_r != `BCCC_FLT_TIMER && !ctrl_r[`BCCC_CTL_SW_OFF] &&
		ts_in_charge_window;
	wire term_hit = current_below_term && bat_above_recharge && !in_reg &&
		ctrl_r[`BCCC_CTL_TERM_EN];
	wire en_rise = chg_en && !en_q_r;
	// timers pause while suspended out of window or not charging
	wire suspend = !ts_in_charge_window || !chg_en;
	wire slow = ctrl_r[`BCCC_CTL_SLOW_EN] &&
		(in_reg || ts_cool_zone);
	// one second tick; when slowed only every second tick is counted
	wire tick = (presc_r == SEC_CYC - 1) && !suspend;
	wire step = tick && (!slow || half_r);
	wire [TMR_W-1:0] hour = 16'd3600;
	reg [TMR_W-1:0] safe_lim;
	reg [TMR_W-1:0] top_lim;

	// safety limit from timer select and low battery; sixteen bits of
	// seconds hold the ten hour limit, longer settings need a wider TMR_W
	// the low battery limit overrides the programmed one while it applies
	always @* begin
		case (ctrl_r[`BCCC_CTL_TMR_LO +: 2])
			2'd0: safe_lim = hour * 16'd5;
			default: safe_lim = hour * 16'd10;
		endcase
		if (bat_below_low)
			safe_lim = hour * SHORT_HRS_W[TMR_W-1:0];
		case (top_sel_r)
			2'd0: top_lim = {TMR_W{1'b0}};
			2'd1: top_lim = 16'd900;
			2'd2: top_lim = 16'd1800;
			default: top_lim = 16'd2700;
		endcase
	end

	wire safe_exp = ctrl_r[`BCCC_CTL_TMR_EN] && state_r == ST_CHG &&
		safe_sec_r >= safe_lim;
	wire top_exp = state_r == ST_TOP && top_sec_r >= top_lim;

	// cycle state machine; a disable leaves any state for idle, which is
	// how a host restarts a finished or failed cycle
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (can_start) state_nxt = ST_CHG;
			ST_CHG: begin
				if (!chg_en)
					state_nxt = ST_IDLE;
				else if (safe_exp)
					state_nxt = ST_FLT;
				else if (term_hit)
					state_nxt = ST_TOP;
			end
			ST_TOP: begin
				if (!chg_en)
					state_nxt = ST_IDLE;
				else if (top_exp)
					state_nxt = ST_DONE;
			end
			ST_DONE: begin
				if (!chg_en)
					state_nxt = ST_IDLE;
				else if (!bat_above_recharge && can_start)
					state_nxt = ST_CHG;
			end
			ST_FLT: if (!chg_en) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// pulse causes: termination, top-off end, timer fault and a change of
	// the boost window while boost is asked for; termination and the start
	// of the top-off segment are one and the same edge, so one pulse
	// serves both
	wire evt_term = state_r == ST_CHG && state_nxt == ST_TOP;
	wire evt_top_end = state_r == ST_TOP && state_nxt == ST_DONE;
	wire evt_fault = state_r == ST_CHG && state_nxt == ST_FLT;
	wire evt_boost = boost_request && (thermistor_fault_r != !ts_in_boost_window);
	wire int_evt = evt_term || evt_top_end || evt_fault || evt_boost;

	// registers written from apb; reg reset bit self clears because the
	// reset value of the control word has it low; a reset request wins
	// over a write landing in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `BCCC_CTL_RESET;
			level_r <= `BCCC_LVL_RESET;
		end else if (reg_rst) begin
			ctrl_r <= `BCCC_CTL_RESET;
			level_r <= `BCCC_LVL_RESET;
		end else if (apb_wr && paddr == `BCCC_OFS_CTRL) begin
			ctrl_r <= pwdata;
		end else if (apb_wr && paddr == `BCCC_OFS_LEVEL) begin
			level_r <= pwdata;
		end
	end

	// read mux; the bus reads zero outside a read access so that a stale
	// word never sits on prdata between transfers
	always @* begin
		prdata = 32'h0000_0000;
		if (apb_acc && !pwrite) begin
			case (paddr)
				`BCCC_OFS_CTRL: prdata = ctrl_r;
				`BCCC_OFS_LEVEL: prdata = level_r;
				`BCCC_OFS_STATUS: prdata = {23'h00_0000, thermistor_fault_r, src_r,
					state_r == ST_TOP, fault_r, phase_r};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// state, timers and captured top-off setting; both timers step on the
	// same one second tick, so suspending or halving the safety timer acts
	// on the top-off timer as well; setting the timer fault takes priority
	// over the clear that an enable rise would make in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			fault_r <= `BCCC_FLT_NONE;
			top_sel_r <= 2'd0;
			presc_r <= 32'h0000_0000;
			half_r <= 1'b0;
			safe_sec_r <= {TMR_W{1'b0}};
			top_sec_r <= {TMR_W{1'b0}};
			en_q_r <= 1'b0;
			term_q_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			en_q_r <= chg_en;
			term_q_r <= state_nxt == ST_TOP || state_nxt == ST_DONE;
			presc_r <= (presc_r == SEC_CYC - 1) ? 32'h0000_0000 :
				presc_r + 32'h0000_0001;
			if (tick)
				half_r <= !half_r;
			if (state_nxt == ST_FLT)
				fault_r <= `BCCC_FLT_TIMER;
			else if (en_rise)
				fault_r <= `BCCC_FLT_NONE;
			// safety count restarts on enable toggle
			if (en_rise || state_r != ST_CHG)
				safe_sec_r <= {TMR_W{1'b0}};
			else if (step && ctrl_r[`BCCC_CTL_TMR_EN])
				safe_sec_r <= safe_sec_r + ONE_SEC;
			if (state_r == ST_CHG && state_nxt == ST_TOP)
				top_sel_r <= ctrl_r[`BCCC_CTL_TOP_LO +: 2];
			if (en_rise || reg_rst || (state_nxt == ST_TOP && !term_q_r))
				top_sec_r <= {TMR_W{1'b0}};
			else if (state_r == ST_TOP && step)
				top_sec_r <= top_sec_r + ONE_SEC;
		end
	end

	// phase, regulator selection and battery switch; the phase is picked
	// again on every clock while charging, so a battery that climbs past the
	// short and precharge levels moves on without a restart
	// current drops to off while suspended, but the phase is kept
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= `BCCC_PH_OFF;
			current_select_r <= `BCCC_ISEL_OFF;
			voltage_select_r <= `BCCC_VSEL_PROG;
			regulation_voltage_r <= 8'h00;
			current_code_r <= 8'h00;
			battery_switch_r <= 1'b0;
		end else begin
			regulation_voltage_r <= level_r[`BCCC_LVL_REGULATION_VOLTAGE_LO +: 8];
			voltage_select_r <= ts_warm_zone && ctrl_r[`BCCC_CTL_WARM_V];
			battery_switch_r <= state_nxt == ST_CHG;
			if (state_nxt == ST_CHG && !suspend) begin
				if (bat_below_short) begin
					phase_r <= `BCCC_PH_PRE;
					current_select_r <= `BCCC_ISEL_SHORT;
					current_code_r <= 8'h00;
				end else if (bat_below_pre) begin
					phase_r <= `BCCC_PH_PRE;
					current_select_r <= `BCCC_ISEL_PRE;
					current_code_r <= level_r[`BCCC_LVL_IPRE_LO +: 8];
				end else begin
					phase_r <= `BCCC_PH_FAST;
					current_code_r <= level_r[`BCCC_LVL_FAST_CHARGE_CURRENT_LO +: 8];
					current_select_r <= (ts_cool_zone &&
						ctrl_r[`BCCC_CTL_COOL_I]) ? `BCCC_ISEL_COOL :
						`BCCC_ISEL_FAST;
				end
			end else begin
				current_select_r <= `BCCC_ISEL_OFF;
				current_code_r <= 8'h00;
				if (state_nxt == ST_TOP || state_nxt == ST_DONE)
					phase_r <= `BCCC_PH_DONE;
				else if (state_nxt == ST_IDLE || state_nxt == ST_FLT)
					phase_r <= `BCCC_PH_OFF;
			end
		end
	end

	// boost qualification against boost thermistor window; the fault bit
	// follows the window with no latch, so it clears as soon as the
	// battery is back inside it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boost_run_r <= 1'b0;
			thermistor_fault_r <= 1'b0;
			src_r <= `BCCC_SRC_NONE;
		end else begin
			boost_run_r <= boost_request && ts_in_boost_window;
			thermistor_fault_r <= boost_request && !ts_in_boost_window;
			src_r <= (boost_request && ts_in_boost_window) ? `BCCC_SRC_BOOST :
				`BCCC_SRC_NONE;
		end
	end

	// interrupt pulse of fixed length; a new event restarts it, so events
	// closer together than one pulse merge into a single longer pulse and
	// the host must read status to tell them apart
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_cnt_r <= 32'h0000_0000;
			host_int_r <= 1'b0;
		end else if (int_evt) begin
			int_cnt_r <= INT_CYC - 1;
			host_int_r <= 1'b1;
		end else if (int_cnt_r != 32'h0000_0000) begin
			int_cnt_r <= int_cnt_r - 32'h0000_0001;
		end else begin
			host_int_r <= 1'b0;
		end
	end

	// indicator: open drain, enable low drives low; the data bit is always
	// low and only the enable moves, so the pin is never driven high and
	// the external pull-up makes the released level
	wire blinking = state_r == ST_FLT || (chg_en && !ts_in_charge_window) ||
		thermistor_fault_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_r <= 32'h0000_0000;
			blink_r <= 1'b0;
			stat_out_r <= 1'b0;
			stat_oe_n_r <= 1'b1;
		end else begin
			if (blink_cnt_r == BLINK_CYC - 1) begin
				blink_cnt_r <= 32'h0000_0000;
				blink_r <= !blink_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
			end
			stat_out_r <= 1'b0;
			if (ctrl_r[`BCCC_CTL_IND_LO +: 2] == `BCCC_IND_OFF)
				stat_oe_n_r <= 1'b1;
			else if (blinking)
				stat_oe_n_r <= blink_r;
			else
				stat_oe_n_r <= !(state_r == ST_CHG || state_r == ST_TOP);
		end
	end

endmodule
`default_nettype wire

// [hw/bccc_map.vh]
// register map, field positions, reset values and timing counts of the charge cycle controller
//
// Contract
// - charging enabled only when enable bit is 1 and enable pin low
// - reset defaults: 4.208 V, 2.048 A, 180 mA pre/term, zone profile, 10 h
// - new cycle needs converter up, enable, nonzero current, no faults, switch on
// - terminate on low current and high voltage; blocked during regulation loops
// - after done, recharge on low battery or enable toggle
// - indicator low charging, high done/disabled, blinking on fault, off when 11
// - phase status: 00 disabled, 01 precharge, 10 fast, 11 done
// - on termination phase becomes 11 and host pulse issued
// - start phase from battery voltage: short, precharge or fast current
// - after termination battery switch off while converter keeps running
// - termination enable 0 before termination prevents termination
// - top-off timer after termination, pauses and stretches with safety timer
// - top-off timer resets on enable rise, termination rise, register reset
// - top-off duration captured at termination; later writes wait for recharge
// - host pulse at top-off start and at top-off expiry
// - charge only inside coldest..hottest window; suspend outside
// - warm zone voltage select 4.1 V; cool zone current cut to 20 percent
// - boost outside boost window: suspend, source status 000, thermistor fault
// - safety limit 2 h below low battery threshold, else programmed duration
// - safety expiry sets fault code 11 and host pulse; enable 0 disables timer
// - half rate during regulation or cool zone unless slowdown enable is 0
// - safety timer holds during fault, resets on enable toggle restart; the count clears to zero instead once the state leaves chg
// - each host interrupt is a single 256 microsecond pulse; events closer than one pulse merge into one longer pulse
`ifndef BCCC_MAP_VH
`define BCCC_MAP_VH

// apb register byte offsets
`define BCCC_OFS_CTRL 12'h000
`define BCCC_OFS_LEVEL 12'h004
`define BCCC_OFS_STATUS 12'h008

// control register fields
`define BCCC_CTL_CHG_EN 0
`define BCCC_CTL_TERM_EN 1
`define BCCC_CTL_TMR_EN 2
`define BCCC_CTL_SLOW_EN 3
`define BCCC_CTL_WARM_V 4
`define BCCC_CTL_COOL_I 5
`define BCCC_CTL_SW_OFF 6
`define BCCC_CTL_REG_RST 7
`define BCCC_CTL_IND_LO 8
`define BCCC_CTL_TMR_LO 10
`define BCCC_CTL_TOP_LO 12
`define BCCC_CTL_RESET 32'h0000_040F

// level register: settings in regulator codes
`define BCCC_LVL_REGULATION_VOLTAGE_LO 0
`define BCCC_LVL_FAST_CHARGE_CURRENT_LO 8
`define BCCC_LVL_IPRE_LO 16
`define BCCC_LVL_ITERM_LO 24
`define BCCC_LVL_RESET 32'h0C0C_2254

// current and voltage selector codes
`define BCCC_ISEL_OFF 3'h0
`define BCCC_ISEL_SHORT 3'h1
`define BCCC_ISEL_PRE 3'h2
`define BCCC_ISEL_FAST 3'h3
`define BCCC_ISEL_COOL 3'h4
`define BCCC_VSEL_PROG 1'b0
`define BCCC_VSEL_4V1 1'b1

// phase and fault codes
`define BCCC_PH_OFF 2'h0
`define BCCC_PH_PRE 2'h1
`define BCCC_PH_FAST 2'h2
`define BCCC_PH_DONE 2'h3
`define BCCC_FLT_NONE 2'h0
`define BCCC_FLT_TIMER 2'h3
`define BCCC_SRC_NONE 3'h0
`define BCCC_SRC_BOOST 3'h7
`define BCCC_IND_OFF 2'h3

// timing in its own units and clock
`define BCCC_CLK_MHZ 200
`define BCCC_INT_US 256
`define BCCC_INT_CYC (`BCCC_INT_US * `BCCC_CLK_MHZ)
`define BCCC_BLINK_CYC 100000000
`define BCCC_SEC_CYC 200000000

`endif

// [verification/bccc_ctrl_asserts.sv]
// concurrent checks on the charge cycle controller ports
`timescale 1ns/1ps
`default_nettype none
`include "bccc_map.vh"
module bccc_ctrl_asserts #(
	parameter INT_CYC = `BCCC_INT_CYC
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// pins and comparators
	input wire charge_enable_n,
	input wire converter_up,
	input wire bat_below_short,
	input wire bat_below_pre,
	input wire ts_in_charge_window,
	input wire ts_cool_zone,
	input wire ts_warm_zone,
	input wire ts_in_boost_window,
	// regulator controls and interrupt
	input wire [2:0] current_select_r,
	input wire voltage_select_r,
	input wire boost_run_r,
	input wire host_int_r
);
	// cycles the interrupt has stood high so far; cleared one cycle after it falls
	reg [31:0] hi_cnt_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hi_cnt_r <= 32'h0000_0000;
		else
			hi_cnt_r <= host_int_r ? hi_cnt_r + 1 : 32'h0000_0000;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// four samples leave room for a two-stage output path
	sequence s_cold_out;
		(!ts_in_charge_window)[*4];
	endsequence
	sequence s_boost_out;
		(!ts_in_boost_window)[*4];
	endsequence
	sequence s_start;
		$rose(current_select_r != `BCCC_ISEL_OFF);
	endsequence
	a_start_needs_en: assert property (
		s_start |-> !$past(charge_enable_n) || !$past(charge_enable_n, 2))
		else $error("charge current started with enable pin high");
	a_start_needs_conv: assert property (
		s_start |-> $past(converter_up) || $past(converter_up, 2))
		else $error("charge current started without converter");
	a_window_stop: assert property (
		s_cold_out |-> current_select_r == `BCCC_ISEL_OFF)
		else $error("charge current outside temperature window");
	a_boost_stop: assert property (
		s_boost_out |-> !boost_run_r)
		else $error("boost kept running outside boost window");
	a_cool_cut: assert property (
		$rose(current_select_r == `BCCC_ISEL_COOL) |->
		$past(ts_cool_zone) || $past(ts_cool_zone, 2))
		else $error("reduced current outside cool zone");
	a_warm_clamp: assert property (
		$rose(voltage_select_r) |-> $past(ts_warm_zone) ||
		$past(ts_warm_zone, 2))
		else $error("voltage clamp outside warm zone");
	a_short_phase: assert property (
		$rose(current_select_r == `BCCC_ISEL_SHORT) |->
		$past(bat_below_short) || $past(bat_below_short, 2))
		else $error("short current with battery above short level");
	a_pre_phase: assert property (
		$rose(current_select_r == `BCCC_ISEL_PRE) |->
		$past(bat_below_pre) || $past(bat_below_pre, 2))
		else $error("precharge current with battery above precharge level");
	a_int_width: assert property (
		$fell(host_int_r) |-> hi_cnt_r >= INT_CYC)
		else $error("host interrupt pulse too short");
endmodule
bind bccc_ctrl bccc_ctrl_asserts #(.INT_CYC(INT_CYC)) u_chk (
	.pclk(pclk), .presetn(presetn), .charge_enable_n(charge_enable_n),
	.converter_up(converter_up), .bat_below_short(bat_below_short),
	.bat_below_pre(bat_below_pre), .ts_in_charge_window(ts_in_charge_window),
	.ts_cool_zone(ts_cool_zone), .ts_warm_zone(ts_warm_zone),
	.ts_in_boost_window(ts_in_boost_window),
	.current_select_r(current_select_r), .voltage_select_r(voltage_select_r),
	.boost_run_r(boost_run_r), .host_int_r(host_int_r));
`default_nettype wire

// [verification/bccc_ctrl_tb.sv]
// self-checking bench for the charge cycle controller
`timescale 1ns/1ps
`default_nettype none
`include "bccc_map.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module bccc_ctrl_tb;
	logic pclk = 1'b0, presetn = 1'b0, pready, pslverr, stat_in, stat_out_r;
	logic stat_oe_n_r, host_int_r, vsel, bsw, brun, psel, penable, pwrite;
	logic en_n = 1'b1, conv = 1'b1, b_short = 1'b0, b_pre = 1'b0, b_low = 1'b0;
	logic b_rech = 1'b1, i_term = 1'b0, icl = 1'b0, ivl = 1'b0, thr = 1'b0;
	logic win = 1'b1, cool = 1'b0, warm = 1'b0, bwin = 1'b1, breq = 1'b0, s;
	logic [2:0] isel;
	logic [7:0] regulation_voltage, icode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	int err_count = 0, n_compared = 0, cyc = 0, ints = 0, t0, n0;
	// short second, blink and pulse counts keep the run brief
	bccc_ctrl #(.SEC_CYC(4), .BLINK_CYC(4), .INT_CYC(8)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .charge_enable_n(en_n),
		.converter_up(conv), .bat_below_short(b_short), .bat_below_pre(b_pre),
		.bat_below_low(b_low), .bat_above_recharge(b_rech),
		.current_below_term(i_term), .input_current_limit_flag(icl),
		.input_voltage_limit_flag(ivl), .thermal_reg_flag(thr),
		.ts_in_charge_window(win), .ts_cool_zone(cool), .ts_warm_zone(warm),
		.ts_in_boost_window(bwin), .boost_request(breq),
		.current_select_r(isel), .voltage_select_r(vsel),
		.regulation_voltage_r(regulation_voltage), .current_code_r(icode),
		.battery_switch_r(bsw), .boost_run_r(brun), .stat_in(stat_in),
		.stat_out_r(stat_out_r), .stat_oe_n_r(stat_oe_n_r),
		.host_int_r(host_int_r));
	bccc_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	initial forever #2.5 pclk = ~pclk;
	// interrupt count; the ceiling covers the long safety timer wait
	always @(posedge pclk) begin
		cyc++;
		if ($rose(host_int_r))
			ints++;
		if (cyc == 70000) begin
			err_count++;
			stop_test;
		end
	end
	task stop_test;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_count);
			if (err_count == 0 && n_compared > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v);
		host.xfer(a, 1'b1, v, d);
	endtask
	task rd(input logic [11:0] a);
		host.xfer(a, 1'b0, 32'h0000_0000, d);
	endtask
	// read status until the masked bits match, bounded by reads
	task poll(input logic [31:0] m, input logic [31:0] v, input int lim);
		for (int i = 0; i < lim; i++) begin
			rd(`BCCC_OFS_STATUS);
			if ((d & m) === v)
				break;
		end
	endtask
	task wsel(input logic [2:0] v);
		for (int i = 0; i < 20 && isel !== v; i++)
			@(posedge pclk);
		`CHK("current select", v, isel)
	endtask
	task t_reset;
		rd(`BCCC_OFS_CTRL);
		`CHK("ctrl reset", `BCCC_CTL_RESET, d)
		rd(`BCCC_OFS_LEVEL);
		`CHK("level reset", `BCCC_LVL_RESET, d)
		rd(`BCCC_OFS_STATUS);
		`CHK("idle phase", `BCCC_PH_OFF, d[1:0])
		rd(12'h00C);
		`CHK("unmapped error", 1'b1, host.err)
		$display("reset test done");
	endtask
	task t_charge;
		wr(`BCCC_OFS_CTRL, 32'h0000_143F);
		b_short <= 1'b1;
		b_pre <= 1'b1;
		en_n <= 1'b0;
		wsel(`BCCC_ISEL_SHORT);
		rd(`BCCC_OFS_STATUS);
		`CHK("short phase", `BCCC_PH_PRE, d[1:0])
		`CHK("indicator low", 1'b0, stat_oe_n_r)
		b_short <= 1'b0;
		wsel(`BCCC_ISEL_PRE);
		b_pre <= 1'b0;
		wsel(`BCCC_ISEL_FAST);
		rd(`BCCC_OFS_STATUS);
		`CHK("fast phase", `BCCC_PH_FAST, d[1:0])
		// codes of the level word as it comes out of reset
		`CHK("fast code", 8'h22, icode)
		`CHK("voltage code", 8'h54, regulation_voltage)
		win <= 1'b0;
		wsel(`BCCC_ISEL_OFF);
		repeat (4) @(posedge pclk);
		`CHK("held off", `BCCC_ISEL_OFF, isel)
		win <= 1'b1;
		cool <= 1'b1;
		wsel(`BCCC_ISEL_COOL);
		cool <= 1'b0;
		warm <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK("warm clamp", `BCCC_VSEL_4V1, vsel)
		warm <= 1'b0;
		// limit flag must hold off termination
		i_term <= 1'b1;
		icl <= 1'b1;
		repeat (40) @(posedge pclk);
		rd(`BCCC_OFS_STATUS);
		`CHK("held by limit", `BCCC_PH_FAST, d[1:0])
		n0 = ints;
		icl <= 1'b0;
		poll(32'h0000_0003, 32'h0000_0003, 40);
		`CHK("done phase", `BCCC_PH_DONE, d[1:0])
		`CHK("top-off flag", 1'b1, d[4])
		`CHK("switch off", 1'b0, bsw)
		`CHK("done int", 1'b1, ints > n0)
		// longer top-off written late must wait for the next cycle
		wr(`BCCC_OFS_CTRL, 32'h0000_343F);
		t0 = cyc;
		n0 = ints;
		poll(32'h0000_0010, 32'h0000_0000, 2500);
		`CHK("top-off short", 1'b1, cyc - t0 < 5000)
		`CHK("top-off ran", 1'b1, cyc - t0 > 3000)
		`CHK("expiry int", 1'b1, ints > n0)
		i_term <= 1'b0;
		$display("charge test done");
	endtask
	task t_recharge;
		wr(`BCCC_OFS_CTRL, 32'h0000_040F);
		b_rech <= 1'b0;
		poll(32'h0000_0003, 32'h0000_0002, 20);
		`CHK("recharge phase", `BCCC_PH_FAST, d[1:0])
		b_rech <= 1'b1;
		wr(`BCCC_OFS_CTRL, 32'h0000_040D);
		i_term <= 1'b1;
		repeat (40) @(posedge pclk);
		rd(`BCCC_OFS_STATUS);
		`CHK("no termination", `BCCC_PH_FAST, d[1:0])
		i_term <= 1'b0;
		$display("recharge test done");
	endtask
	task t_timer;
		wr(`BCCC_OFS_CTRL, 32'h0000_000F);
		b_low <= 1'b1;
		en_n <= 1'b1;
		repeat (3) @(posedge pclk);
		en_n <= 1'b0;
		t0 = cyc;
		poll(32'h0000_000C, 32'h0000_000C, 16000);
		`CHK("timer fault", `BCCC_FLT_TIMER, d[3:2])
		// two hours of four-cycle seconds, plus the poll's own latency
		n0 = cyc - t0;
		`CHK("low battery limit", 1'b1, n0 > 28790 && n0 < 28840)
		n0 = 0;
		s = stat_oe_n_r;
		repeat (20) begin
			@(posedge pclk);
			if (stat_oe_n_r !== s)
				n0++;
			s = stat_oe_n_r;
		end
		`CHK("blinking", 1'b1, n0 > 1)
		en_n <= 1'b1;
		repeat (3) @(posedge pclk);
		en_n <= 1'b0;
		repeat (100) @(posedge pclk);
		rd(`BCCC_OFS_STATUS);
		`CHK("timer restarted", `BCCC_FLT_NONE, d[3:2])
		b_low <= 1'b0;
		$display("safety timer test done");
	endtask
	task t_boost;
		en_n <= 1'b1;
		conv <= 1'b0;
		breq <= 1'b1;
		poll(32'h0000_00E0, 32'h0000_00E0, 20);
		`CHK("boost source", `BCCC_SRC_BOOST, d[7:5])
		bwin <= 1'b0;
		poll(32'h0000_01E0, 32'h0000_0100, 20);
		`CHK("boost fault", 4'h8, d[8:5])
		`CHK("boost held", 1'b0, brun)
		repeat (4) @(posedge pclk);
		bwin <= 1'b1;
		poll(32'h0000_01E0, 32'h0000_00E0, 20);
		`CHK("boost back", 4'h7, d[8:5])
		breq <= 1'b0;
		conv <= 1'b1;
		$display("boost test done");
	endtask
	task t_ind;
		en_n <= 1'b0;
		wr(`BCCC_OFS_CTRL, 32'h0000_070F);
		poll(32'h0000_0003, 32'h0000_0002, 20);
		`CHK("indicator off", 1'b1, stat_oe_n_r)
		en_n <= 1'b1;
		poll(32'h0000_0003, 32'h0000_0000, 20);
		`CHK("disabled phase", `BCCC_PH_OFF, d[1:0])
		$display("indicator test done");
	endtask
	// reset for eight cycles, then the scenarios in turn
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_charge;
		t_recharge;
		t_timer;
		t_boost;
		t_ind;
		stop_test;
	end
endmodule
`default_nettype wire

// [verification/bccc_host.sv]
// host model: apb master through which settings reach the controller
`timescale 1ns/1ps
`default_nettype none
module bccc_host (
	// clock and apb answer
	input wire logic pclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// apb request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	logic err;
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// request held until pready is seen high at a rising edge
	task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= wd;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			// one idle edge so a following request never re-raises psel
			// in the time step that released it
			@(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire
